// >>> logic/astr_regs.svh
// Register map, field positions and timing counts of the serial transmitter
`ifndef ASTR_REGS_SVH
`define ASTR_REGS_SVH
`define ASTR_CLK_MHZ 250
`define ASTR_MCLK_DIV 250
`define ASTR_HS_BIT 10
`define ASTR_LS_BIT 80
`define ASTR_HS_HALF 5
`define ASTR_LS_HALF 40
`define ASTR_HS_GAP 40
`define ASTR_LS_GAP 320
`define ASTR_HS_RXTO 20
`define ASTR_LS_RXTO 160
`define ASTR_T_TXR_LOW_NS 840
`define ASTR_T_TXR_HIGH_NS 50
`define ASTR_TXR_LOW_CYC ((`ASTR_T_TXR_LOW_NS * `ASTR_CLK_MHZ) / 1000)
`define ASTR_TXR_HIGH_CYC ((`ASTR_T_TXR_HIGH_NS * `ASTR_CLK_MHZ) / 1000)
`define ASTR_OFF_CTRL 6'h00
`define ASTR_OFF_TXLO 6'h04
`define ASTR_OFF_TXHI 6'h08
`define ASTR_OFF_CMD 6'h0c
`define ASTR_OFF_STAT 6'h10
`define ASTR_OFF_RX1LO 6'h14
`define ASTR_OFF_RX1HI 6'h18
`define ASTR_OFF_RX2LO 6'h1c
`define ASTR_OFF_RX2HI 6'h20
`define ASTR_CTRL_RST 16'h0020
`define ASTR_CTRL_LOOP 5
`define ASTR_CTRL_RX1_DEC 6
`define ASTR_CTRL_RX2_DEC 9
`define ASTR_CTRL_PINV 12
`define ASTR_CTRL_TXRATE 13
`define ASTR_CTRL_RXRATE 14
`define ASTR_CMD_GO 0
`define ASTR_CMD_RPT 1
`define ASTR_STAT_TXR 0
`define ASTR_STAT_RX1N 1
`define ASTR_STAT_RX2N 2
`define ASTR_STAT_CNT 4
`endif

// >>> logic/astr_pkg.sv
// Types of the serial transmitter
package astr_pkg;
	typedef enum logic [4:0] {
		TX_IDLE = 5'h01,
		TX_LOAD = 5'h02,
		TX_DRIVE = 5'h04,
		TX_NULL = 5'h08,
		TX_GAP = 5'h10
	} astr_tx_state_e;
endpackage

// >>> logic/astr_core.sv
// Serial word transmitter with FIFO, loopback receivers and repeater path
// Behaviour
// - Bit is two equal halves; word gap follows
// - Ready flag rises when all loaded words sent
// - Bit 32 gives odd parity, even when inverted
// - Self-test routes transmit stream into both receivers
// - Receiver 2 gets the complemented stream
// - Line outputs keep driving during self-test
// - Unread received word is replaced by newer
// - FIFO holds eight words, ignores loads when full
// - Receiver ready flag holds until both bytes read
// - Repeater reads also load the transmit FIFO
// - Master reset stops links, empties FIFO, flags
// - Master reset keeps the control word
// - Receiver ready flag in time after bit 32
// - First bit on line quickly after go
// - Ready flag falls soon after high-byte load
// - Ready flag rises soon after last bit
// - Rate bit selects divide by ten or eighty
// - Two byte loads form one FIFO word
// - Go moves oldest word into shift register
// - Receiver ready only on label match or disabled
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
`include "astr_regs.svh"
module astr_core #(
	parameter int MCLK_DIV = `ASTR_MCLK_DIV,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and resets
	input wire logic clk,
	input wire logic reset,
	input wire logic chip_reset_n,
	// Avalon-MM slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Line interface, digital levels
	output logic line_out_pos,
	output logic line_out_neg,
	input wire logic rx1_in_pos,
	input wire logic rx1_in_neg,
	input wire logic rx2_in_pos,
	input wire logic rx2_in_neg,
	// Flags
	output logic tx_ready,
	output logic rx1_word_ready_n,
	output logic rx2_word_ready_n
);
	localparam int PW = $clog2(FIFO_DEPTH);
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam int TXR_LOW_CYC = `ASTR_TXR_LOW_CYC;
	localparam int TXR_HIGH_CYC = `ASTR_TXR_HIGH_CYC;

	function automatic logic [31:0] pack_word(input logic [15:0] lo, input logic [15:0] hi);
		logic [31:0] w;
		w = 32'h0;
		for (int k = 0; k < 8; k++) begin
			w[k] = lo[7 - k];
		end
		w[12:8] = lo[15:11];
		w[29] = lo[9];
		w[30] = lo[10];
		w[28:13] = hi;
		return w;
	endfunction

	function automatic logic [15:0] low_of(input logic [31:0] w);
		logic [15:0] lo;
		lo = 16'h0;
		for (int k = 0; k < 8; k++) begin
			lo[7 - k] = w[k];
		end
		lo[15:11] = w[12:8];
		lo[10] = w[30];
		lo[9] = w[29];
		lo[8] = w[31];
		return lo;
	endfunction

	// Master reset spares the control word, the plain reset clears all
	logic mr;
	assign mr = reset | ~chip_reset_n;

	// Bus slave state
	logic ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [15:0] ctrl_reg, ctrl_next;
	logic go_reg, go_next, rpt_reg, rpt_next;
	logic req, acc, wr_acc, rd_acc;
	logic control_word_strobe, low_byte_load_strobe, high_byte_load_strobe;
	logic [15:0] load_data;
	logic [1:0] rd_lo, rd_hi;
	logic [31:0] rx_data [2];
	logic [1:0] rx_rdy_n;
	logic [CW-1:0] count_reg;
	logic ready_reg;

	// One wait cycle per access keeps read data registered
	assign req = avs_read | avs_write;
	assign acc = req & ack_reg;
	assign wr_acc = acc & avs_write;
	assign rd_acc = acc & avs_read;
	assign avs_waitrequest = req & ~ack_reg;
	assign avs_readdata = rdata_reg;
	assign control_word_strobe = wr_acc & (avs_address == `ASTR_OFF_CTRL);
	assign rd_lo[0] = rd_acc & (avs_address == `ASTR_OFF_RX1LO);
	assign rd_hi[0] = rd_acc & (avs_address == `ASTR_OFF_RX1HI);
	assign rd_lo[1] = rd_acc & (avs_address == `ASTR_OFF_RX2LO);
	assign rd_hi[1] = rd_acc & (avs_address == `ASTR_OFF_RX2HI);
	assign low_byte_load_strobe = (wr_acc & (avs_address == `ASTR_OFF_TXLO))
		| (rpt_reg & |rd_lo);
	assign high_byte_load_strobe = (wr_acc & (avs_address == `ASTR_OFF_TXHI))
		| (rpt_reg & |rd_hi);

	always_comb begin
		load_data = avs_writedata[15:0];
		if (rpt_reg && rd_acc) begin
			if (|rd_lo) begin
				load_data = low_of(rd_lo[1] ? rx_data[1] : rx_data[0]);
			end else begin
				load_data = rd_hi[1] ? rx_data[1][28:13] : rx_data[0][28:13];
			end
		end
	end

	always_comb begin
		ack_next = req & ~ack_reg;
		ctrl_next = control_word_strobe ? avs_writedata[15:0] : ctrl_reg;
		go_next = go_reg;
		rpt_next = rpt_reg;
		if (wr_acc && avs_address == `ASTR_OFF_CMD) begin
			go_next = avs_writedata[`ASTR_CMD_GO];
			rpt_next = avs_writedata[`ASTR_CMD_RPT];
		end
		rdata_next = rdata_reg;
		if (req && !ack_reg) begin
			rdata_next = 32'h0;
			case (avs_address)
				`ASTR_OFF_CTRL: rdata_next[15:0] = ctrl_reg;
				`ASTR_OFF_CMD: rdata_next[1:0] = {rpt_reg, go_reg};
				`ASTR_OFF_STAT: begin
					rdata_next[`ASTR_STAT_TXR] = ready_reg;
					rdata_next[`ASTR_STAT_RX1N] = rx_rdy_n[0];
					rdata_next[`ASTR_STAT_RX2N] = rx_rdy_n[1];
					rdata_next[`ASTR_STAT_CNT +: CW] = count_reg;
				end
				`ASTR_OFF_RX1LO: rdata_next[15:0] = low_of(rx_data[0]);
				`ASTR_OFF_RX1HI: rdata_next[15:0] = rx_data[0][28:13];
				`ASTR_OFF_RX2LO: rdata_next[15:0] = low_of(rx_data[1]);
				`ASTR_OFF_RX2HI: rdata_next[15:0] = rx_data[1][28:13];
				default: rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0;
			ctrl_reg <= `ASTR_CTRL_RST;
			go_reg <= 1'b0;
			rpt_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			go_reg <= go_next;
			rpt_reg <= rpt_next;
		end
	end

	// Transmitter state
	astr_pkg::astr_tx_state_e state_reg, state_next;
	logic [7:0] pre_reg, pre_next;
	logic [8:0] cnt_reg, cnt_next;
	logic [4:0] bit_reg, bit_next;
	logic [31:0] sh_reg, sh_next;
	logic [15:0] lo_hold_reg, lo_hold_next;
	logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [CW-1:0] count_next;
	logic pos_reg, pos_next, neg_reg, neg_next, ready_next;
	logic [30:0] fifo_mem [FIFO_DEPTH];
	logic mtick, push, pop, fifo_full, gap_load;
	logic [31:0] packed_word;
	logic [8:0] half_len, gap_len;
	logic [31:0] word;

	assign mtick = pre_reg == 8'(MCLK_DIV - 1);
	assign half_len = ctrl_reg[`ASTR_CTRL_TXRATE] ? 9'(`ASTR_LS_HALF) : 9'(`ASTR_HS_HALF);
	assign gap_len = ctrl_reg[`ASTR_CTRL_TXRATE] ? 9'(`ASTR_LS_GAP) : 9'(`ASTR_HS_GAP);
	assign fifo_full = count_reg == CW'(FIFO_DEPTH);
	assign push = high_byte_load_strobe & ~fifo_full;
	// Back-to-back words load straight from the gap so it stays exact
	assign gap_load = state_reg == astr_pkg::TX_GAP && mtick && cnt_reg == gap_len - 9'h1
		&& count_reg != '0 && go_reg;
	assign pop = (state_reg == astr_pkg::TX_LOAD) | gap_load;
	// Bit 32 comes from the parity generator, never from the FIFO
	assign word = {ctrl_reg[`ASTR_CTRL_PINV] ^ ~(^fifo_mem[rd_ptr_reg]),
		fifo_mem[rd_ptr_reg]};
	assign packed_word = pack_word(lo_hold_reg, load_data);

	always_comb begin
		pre_next = mtick ? 8'h0 : pre_reg + 8'h1;
		lo_hold_next = low_byte_load_strobe ? load_data : lo_hold_reg;
		wr_ptr_next = push ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
		rd_ptr_next = pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
		count_next = CW'(count_reg + CW'(push) - CW'(pop));
		state_next = state_reg;
		cnt_next = cnt_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		pos_next = pos_reg;
		neg_next = neg_reg;
		case (state_reg)
			astr_pkg::TX_IDLE: begin
				if (go_reg && count_reg != '0) begin
					state_next = astr_pkg::TX_LOAD;
				end
			end
			astr_pkg::TX_LOAD: begin
				sh_next = word;
				bit_next = 5'h0;
				cnt_next = 9'h0;
				pos_next = word[0];
				neg_next = ~word[0];
				state_next = astr_pkg::TX_DRIVE;
			end
			astr_pkg::TX_DRIVE: begin
				if (mtick) begin
					cnt_next = cnt_reg + 9'h1;
					if (cnt_reg == half_len - 9'h1) begin
						cnt_next = 9'h0;
						pos_next = 1'b0;
						neg_next = 1'b0;
						state_next = astr_pkg::TX_NULL;
					end
				end
			end
			astr_pkg::TX_NULL: begin
				if (mtick) begin
					cnt_next = cnt_reg + 9'h1;
					if (cnt_reg == half_len - 9'h1) begin
						cnt_next = 9'h0;
						if (bit_reg == 5'h1f) begin
							state_next = astr_pkg::TX_GAP;
						end else begin
							bit_next = bit_reg + 5'h1;
							sh_next = {1'b0, sh_reg[31:1]};
							pos_next = sh_reg[1];
							neg_next = ~sh_reg[1];
							state_next = astr_pkg::TX_DRIVE;
						end
					end
				end
			end
			astr_pkg::TX_GAP: begin
				if (mtick) begin
					cnt_next = cnt_reg + 9'h1;
					if (cnt_reg == gap_len - 9'h1) begin
						cnt_next = 9'h0;
						state_next = astr_pkg::TX_IDLE;
						if (gap_load) begin
							sh_next = word;
							bit_next = 5'h0;
							pos_next = word[0];
							neg_next = ~word[0];
							state_next = astr_pkg::TX_DRIVE;
						end
					end
				end
			end
			default: state_next = astr_pkg::TX_IDLE;
		endcase
		// Dropping go mid-word loses that word
		if (!go_reg && state_reg != astr_pkg::TX_IDLE && state_reg != astr_pkg::TX_LOAD) begin
			state_next = astr_pkg::TX_IDLE;
			pos_next = 1'b0;
			neg_next = 1'b0;
		end
		ready_next = count_next == '0 && (state_next == astr_pkg::TX_IDLE
			|| state_next == astr_pkg::TX_GAP);
	end

	always_ff @(posedge clk) begin
		if (mr) begin
			state_reg <= astr_pkg::TX_IDLE;
			pre_reg <= 8'h0;
			cnt_reg <= 9'h0;
			bit_reg <= 5'h0;
			sh_reg <= 32'h0;
			lo_hold_reg <= 16'h0;
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			pos_reg <= 1'b0;
			neg_reg <= 1'b0;
			ready_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			lo_hold_reg <= lo_hold_next;
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= count_next;
			pos_reg <= pos_next;
			neg_reg <= neg_next;
			ready_reg <= ready_next;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			fifo_mem[wr_ptr_reg] <= packed_word[30:0];
		end
	end

	assign line_out_pos = pos_reg;
	assign line_out_neg = neg_reg;
	assign tx_ready = ready_reg;

	// Receivers; self-test takes the transmit stream, not the pins
	logic self_test;
	logic [1:0] in_pos, in_neg;
	assign self_test = ~ctrl_reg[`ASTR_CTRL_LOOP];
	assign in_pos[0] = self_test ? pos_reg : rx1_in_pos;
	assign in_neg[0] = self_test ? neg_reg : rx1_in_neg;
	assign in_pos[1] = self_test ? neg_reg : rx2_in_pos;
	assign in_neg[1] = self_test ? pos_reg : rx2_in_neg;

	for (genvar i = 0; i < 2; i++) begin : g_rx
		logic act_reg, rdy_n_reg, rdy_n_next, got_lo_reg, got_lo_next, got_hi_reg, got_hi_next;
		logic [5:0] bits_reg, bits_next;
		logic [8:0] to_reg, to_next;
		logic [31:0] sh_r, sh_n, data_reg, data_next, full;
		logic act, start, word_complete_pulse, match;
		logic [8:0] to_len;
		assign act = in_pos[i] | in_neg[i];
		assign start = act & ~act_reg;
		assign full = {in_pos[i], sh_r[31:1]};
		assign to_len = ctrl_reg[`ASTR_CTRL_RXRATE] ? 9'(`ASTR_LS_RXTO) : 9'(`ASTR_HS_RXTO);
		assign word_complete_pulse = start & (bits_reg == 6'd31);
		assign match = ~ctrl_reg[`ASTR_CTRL_RX1_DEC + 3 * i]
			| (full[9:8] == ctrl_reg[`ASTR_CTRL_RX1_DEC + 3 * i + 1 +: 2]);
		always_comb begin
			sh_n = start ? full : sh_r;
			bits_next = start ? (word_complete_pulse ? 6'h0 : bits_reg + 6'h1) : bits_reg;
			to_next = act ? 9'h0 : ((mtick && to_reg != to_len) ? to_reg + 9'h1 : to_reg);
			if (!act && to_reg == to_len) begin
				bits_next = 6'h0;
			end
			data_next = data_reg;
			got_lo_next = got_lo_reg | rd_lo[i];
			got_hi_next = got_hi_reg | rd_hi[i];
			rdy_n_next = rdy_n_reg | (got_lo_next & got_hi_next);
			if (word_complete_pulse && match) begin
				data_next = {~(^full), full[30:0]};
				got_lo_next = 1'b0;
				got_hi_next = 1'b0;
				rdy_n_next = 1'b0;
			end
		end
		always_ff @(posedge clk) begin
			if (mr) begin
				act_reg <= 1'b0;
				sh_r <= 32'h0;
				bits_reg <= 6'h0;
				to_reg <= 9'h0;
				data_reg <= 32'h0;
				got_lo_reg <= 1'b0;
				got_hi_reg <= 1'b0;
				rdy_n_reg <= 1'b1;
			end else begin
				act_reg <= act;
				sh_r <= sh_n;
				bits_reg <= bits_next;
				to_reg <= to_next;
				data_reg <= data_next;
				got_lo_reg <= got_lo_next;
				got_hi_reg <= got_hi_next;
				rdy_n_reg <= rdy_n_next;
			end
		end
		assign rx_data[i] = data_reg;
		assign rx_rdy_n[i] = rdy_n_reg;
	end
	assign rx1_word_ready_n = rx_rdy_n[0];
	assign rx2_word_ready_n = rx_rdy_n[1];

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_fifo_full_drop: assert property (fifo_full && !pop |=> fifo_full) else $error("full lost");
	a_txr_fall: assert property (push && state_reg == astr_pkg::TX_IDLE |-> ##[1:TXR_LOW_CYC]
		!tx_ready) else $error("ready not low");
	a_txr_rise: assert property (state_reg == astr_pkg::TX_NULL && state_next == astr_pkg::TX_GAP
		&& count_reg == '0 && !push |-> ##[1:TXR_HIGH_CYC] tx_ready) else $error("ready late");
	a_parity_odd: assert property (pop && !ctrl_reg[`ASTR_CTRL_PINV] |=> ^sh_reg)
		else $error("parity wrong");
	a_half_len: assert property ($rose(state_reg == astr_pkg::TX_NULL) |->
		(line_out_pos | line_out_neg) == 1'b0 && cnt_reg == 9'h0) else $error("half bad");
	a_line_code: assert property (!(line_out_pos && line_out_neg)) else $error("both driven");
	a_loop_swap: assert property (self_test |-> in_pos[1] == line_out_neg && in_pos[0] == line_out_pos)
		else $error("loopback wrong");
	a_go_start: assert property (state_reg == astr_pkg::TX_IDLE && go_reg && count_reg != '0 && !mr
		|-> ##2 line_out_pos | line_out_neg) else $error("no first bit");
	a_mr_clear: assert property (!chip_reset_n |=> count_reg == '0 && tx_ready && rx_rdy_n == 2'b11
		&& pre_reg == 8'h0) else $error("reset left state");
	a_ctrl_keep: assert property (!control_word_strobe |=> $stable(ctrl_reg))
		else $error("ctrl changed");
	c_word_sent: cover property (state_reg == astr_pkg::TX_GAP && tx_ready);
	c_fifo_full: cover property (fifo_full && high_byte_load_strobe);
	c_rx_ready: cover property ($fell(rx1_word_ready_n));
	c_repeat: cover property (rpt_reg && push);
endmodule

// >>> bench/astr_line_model.sv
// Line-side partner: decodes the transmitted stream and echoes it to receiver 1
`timescale 1ns/100ps
module astr_line_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Transmit line
	input wire logic line_out_pos,
	input wire logic line_out_neg,
	// Echo into receiver 1
	output logic rx_pos,
	output logic rx_neg
);
	logic [32:1] bits;
	int n, words, drv, drv_len, idle, gap_len, bad;
	// Wire echo, no analog delay modelled
	assign rx_pos = line_out_pos;
	assign rx_neg = line_out_neg;
	always @(posedge clk) begin
		if (reset) begin
			n = 0;
			words = 0;
			drv = 0;
			drv_len = 0;
			idle = 0;
			gap_len = 0;
			bad = 0;
		end else begin
			if (line_out_pos & line_out_neg)
				bad = bad + 1;
			if (line_out_pos | line_out_neg) begin
				if (drv == 0) begin
					// Long silence means an abandoned word
					if (n == 32 || idle > 400)
						n = 1;
					else
						n = n + 1;
					if (n == 1)
						gap_len = idle;
					bits[n] = line_out_pos;
					if (n == 32)
						words = words + 1;
				end
				drv = drv + 1;
				idle = 0;
			end else begin
				if (drv != 0)
					drv_len = drv;
				drv = 0;
				idle = idle + 1;
			end
		end
	end
endmodule

// >>> bench/tb.sv
// Self-checking bench of the serial transmitter
`timescale 1ns/100ps
`include "astr_regs.svh"
module tb;
	logic clk, reset, chip_reset_n, avs_read, avs_write, p;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic avs_waitrequest, line_out_pos, line_out_neg, rx_p, rx_n;
	logic tx_ready, rx1_word_ready_n, rx2_word_ready_n;
	logic [15:0] lo [9];
	logic [15:0] hi [9];
	int err_count, n_tests, seed, cyc, base;
	// One master tick per clock keeps the run short
	astr_core #(.MCLK_DIV(1), .FIFO_DEPTH(8)) i_dut (.clk(clk), .reset(reset),
		.chip_reset_n(chip_reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .line_out_pos(line_out_pos),
		.line_out_neg(line_out_neg), .rx1_in_pos(rx_p), .rx1_in_neg(rx_n),
		.rx2_in_pos(1'b0), .rx2_in_neg(1'b0), .tx_ready(tx_ready),
		.rx1_word_ready_n(rx1_word_ready_n), .rx2_word_ready_n(rx2_word_ready_n));
	astr_line_model i_line (.clk(clk), .reset(reset), .line_out_pos(line_out_pos),
		.line_out_neg(line_out_neg), .rx_pos(rx_p), .rx_neg(rx_n));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	task wrap_up;
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			wrap_up;
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("Error %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// Request held until waitrequest is seen low at a rising edge
	task bus(input logic r, input logic [5:0] a, input logic [15:0] d);
		int c;
		c = 0;
		avs_read <= r;
		avs_write <= ~r;
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && c < 100) begin
			@(posedge clk);
			c++;
		end
		if (c == 100)
			err_count++;
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task wt(input int s, input int t, input int lim);
		int c;
		bit ok;
		c = 0;
		ok = 0;
		while (!ok && c < lim) begin
			@(negedge clk);
			case (s)
				0: ok = (tx_ready === 1'b1);
				1: ok = (rx1_word_ready_n === 1'b0);
				2: ok = (rx2_word_ready_n === 1'b0);
				3: ok = (i_line.words >= t);
				default: ok = ((line_out_pos | line_out_neg) === 1'b1);
			endcase
			c++;
		end
		chk($sformatf("wait %0d", s), 1, ok);
		@(posedge clk);
	endtask
	task load(input int cnt);
		for (int k = 0; k < cnt; k++) begin
			lo[k] = $random(seed) & 16'hfeff;
			hi[k] = $random(seed);
			bus(0, `ASTR_OFF_TXLO, lo[k]);
			bus(0, `ASTR_OFF_TXHI, hi[k]);
		end
	endtask
	function automatic logic [32:1] xb(input logic [15:0] l, input logic [15:0] h,
		input logic pi);
		logic [32:1] b;
		for (int i = 1; i <= 8; i++)
			b[i] = l[8-i];
		for (int i = 9; i <= 13; i++)
			b[i] = l[i+2];
		for (int i = 14; i <= 29; i++)
			b[i] = h[i-14];
		b[30] = l[9];
		b[31] = l[10];
		b[32] = (^b[31:1]) ^ ~pi;
		return b;
	endfunction
	task done(input string nm);
		$display("Test %s finished", nm);
	endtask
	initial begin
		seed = 70;
		cyc = 0;
		err_count = 0;
		n_tests = 0;
		reset = 1;
		chip_reset_n = 1;
		avs_read = 0;
		avs_write = 0;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		repeat (20) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		bus(1, `ASTR_OFF_CTRL, 0);
		chk("ctrl reset", 32'h20, q);
		bus(1, `ASTR_OFF_STAT, 0);
		chk("stat reset", 32'h7, q);
		bus(1, 6'h3c, 0);
		chk("unmapped", 32'h0, q);
		done("reset");
		// Normal mode, three words back to back, random parity sense
		p = $random(seed);
		bus(0, `ASTR_OFF_CTRL, {3'h0, p, 12'h020});
		load(3);
		bus(1, `ASTR_OFF_STAT, 0);
		chk("stat loaded", 32'h36, q);
		bus(0, `ASTR_OFF_CMD, 16'h0001);
		wt(4, 0, 30);
		for (int k = 0; k < 3; k++) begin
			wt(3, k + 1, 400);
			chk("line word", xb(lo[k], hi[k], p), i_line.bits);
		end
		wt(0, 0, 30);
		chk("drive half", 5, i_line.drv_len);
		chk("word gap", 45, i_line.gap_len);
		bus(0, `ASTR_OFF_CMD, 16'h0000);
		wt(1, 0, 50);
		bus(1, `ASTR_OFF_RX1LO, 0);
		chk("rx1 lo", {16'h0, lo[2] | {7'h00, p, 8'h00}}, q);
		chk("rx1 held", 0, rx1_word_ready_n);
		bus(1, `ASTR_OFF_RX1HI, 0);
		chk("rx1 hi", hi[2], q);
		chk("rx1 freed", 1, rx1_word_ready_n);
		chk("rx2 idle", 1, rx2_word_ready_n);
		chk("short bits", 0, i_line.bad);
		done("normal");
		// Self-test loopback, then repeat the received word
		bus(0, `ASTR_OFF_CTRL, 16'h0000);
		base = i_line.words;
		load(1);
		bus(0, `ASTR_OFF_CMD, 16'h0001);
		wt(3, base + 1, 400);
		chk("loop line", xb(lo[0], hi[0], 0), i_line.bits);
		wt(1, 0, 50);
		wt(2, 0, 50);
		wt(0, 0, 60);
		bus(0, `ASTR_OFF_CMD, 16'h0000);
		bus(1, `ASTR_OFF_RX2HI, 0);
		chk("rx2 hi", {16'h0, ~hi[0]}, q);
		chk("rx2 held", 0, rx2_word_ready_n);
		bus(1, `ASTR_OFF_RX2LO, 0);
		chk("rx2 lo", {16'h0, ~lo[0] & 16'hfeff}, q);
		bus(0, `ASTR_OFF_CMD, 16'h0002);
		bus(1, `ASTR_OFF_RX1LO, 0);
		bus(1, `ASTR_OFF_RX1HI, 0);
		bus(1, `ASTR_OFF_STAT, 0);
		chk("repeat stat", 32'h16, q);
		bus(0, `ASTR_OFF_CMD, 16'h0003);
		wt(3, base + 2, 400);
		chk("repeat line", xb(lo[0], hi[0], 0), i_line.bits);
		wt(0, 0, 60);
		bus(0, `ASTR_OFF_CMD, 16'h0000);
		done("loopback");
		// Ninth load dropped while the FIFO is full
		bus(0, `ASTR_OFF_CTRL, 16'h0020);
		base = i_line.words;
		load(9);
		bus(1, `ASTR_OFF_STAT, 0);
		chk("fifo count", 8, (q >> 4) & 32'hf);
		bus(0, `ASTR_OFF_CMD, 16'h0001);
		wt(3, base + 8, 3200);
		chk("last word", xb(lo[7], hi[7], 0), i_line.bits);
		wt(0, 0, 60);
		repeat (100) @(posedge clk);
		chk("word count", base + 8, i_line.words);
		done("full");
		// Master reset in mid-word keeps control and command
		base = i_line.words;
		load(2);
		wt(3, base + 1, 400);
		repeat (100) @(posedge clk);
		chip_reset_n <= 1'b0;
		@(posedge clk);
		chip_reset_n <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk("lines idle", 0, line_out_pos | line_out_neg);
		chk("flags", 3'h7, {rx2_word_ready_n, rx1_word_ready_n, tx_ready});
		@(posedge clk);
		bus(1, `ASTR_OFF_STAT, 0);
		chk("stat mr", 32'h7, q);
		bus(1, `ASTR_OFF_CTRL, 0);
		chk("ctrl mr", 32'h20, q);
		bus(1, `ASTR_OFF_CMD, 0);
		chk("cmd mr", 32'h1, q);
		bus(0, `ASTR_OFF_CMD, 16'h0000);
		repeat (500) @(posedge clk);
		chk("no resume", base + 1, i_line.words);
		done("master reset");
		// Slow rate
		bus(0, `ASTR_OFF_CTRL, 16'h2020);
		base = i_line.words;
		load(1);
		bus(0, `ASTR_OFF_CMD, 16'h0001);
		wt(3, base + 1, 3000);
		chk("slow word", xb(lo[0], hi[0], 0), i_line.bits);
		wt(0, 0, 120);
		chk("slow half", 40, i_line.drv_len);
		bus(0, `ASTR_OFF_CMD, 16'h0000);
		done("slow rate");
		wrap_up;
	end
endmodule
